// ===== design/aqs_cfg.svh
// Offsets, field positions, reset values and timing counts of the queue sequencer.
// Assumes a 9-bit word address and 16-bit data on the register port.
`ifndef AQS_CFG_SVH
`define AQS_CFG_SVH

`define AQS_REG_CTRL1 9'h100
`define AQS_REG_CTRL2 9'h101
`define AQS_REG_GLOBAL 9'h102
`define AQS_REG_STATUS 9'h103
`define AQS_RGN_CMD 2'h0
`define AQS_RGN_RIGHT 2'h1
`define AQS_RGN_SIGNED 2'h2
`define AQS_RGN_LEFT 2'h3

`define AQS_CTRL1_MASK 16'h00df
`define AQS_CTRL2_MASK 16'h7fff
`define AQS_GLOBAL_MASK 16'hff3f
`define AQS_CTRL1_RST 16'h0000
`define AQS_CTRL2_RST 16'h4000
`define AQS_GLOBAL_RST 16'h0300

`define AQS_F_MODE 3:0
`define AQS_F_SSE 4
`define AQS_F_RESUME 5
`define AQS_F_IE_DONE 6
`define AQS_F_IE_PAUSE 7
`define AQS_F_BASE 14:8
`define AQS_F_STOP 0
`define AQS_F_FREEZE 1
`define AQS_F_TMR_EXP 5:2
`define AQS_F_PRESC 15:8

`define AQS_END_CHAN 6'h3f
`define AQS_INIT_SAMPLE_CONVERTER_CLOCK 5'h02
`define AQS_TMR_MIN_EXP 7
`define AQS_TMR_MAX_EXP 4'ha

`endif

// ===== design/aqs_pkg.sv
// Types shared by the queue sequencer.
// Constants live in aqs_cfg.svh.
package aqs_pkg;

  typedef enum logic [3:0] {
    AQS_DISABLED,
    AQS_SW_SINGLE,
    AQS_SW_CONT,
    AQS_EXT_SINGLE,
    AQS_EXT_CONT,
    AQS_TMR_SINGLE,
    AQS_TMR_CONT,
    AQS_GATE_SINGLE,
    AQS_GATE_CONT
  } aqs_mode_e;

  typedef enum logic [1:0] {
    AQS_ST_IDLE,
    AQS_ST_INIT,
    AQS_ST_FINAL,
    AQS_ST_CONV
  } aqs_state_e;

  typedef struct packed {
    logic spare;
    logic pause;
    logic [1:0] sample_sel;
    logic [5:0] chan;
  } aqs_cmd_s;

  // Unused codes act as disabled
  function automatic aqs_mode_e aqs_decode_mode(input logic [3:0] code);
    aqs_decode_mode = (code > 4'h8) ? AQS_DISABLED : aqs_mode_e'(code);
  endfunction : aqs_decode_mode

endpackage : aqs_pkg

// ===== design/aqs_sequencer.sv
// Two-queue conversion sequencer with command and result tables.
// Assumes a converter core that starts on conv_start_r and answers with conv_done and its result.
//
// Overview of operation
// - 64 ten-bit command entries, software-owned
// - Upper six command bits read zero
// - Result stored at same index as command
// - Queue one at slot zero, two at base
// - Start by software, timer, edge or gate
// - Single scans need enable; continuous stays armed
// - Final sample 2/4/8/16 after initial sample
// - Commands run ascending until end or pause
// - Pause halts, flags, continues next trigger
// - Channel 63 marks end of queue
// - Queue one ends at base; table end
// - End sets completion flag, optional interrupt
// - Queue one trigger preempts queue two
// - Resume bit picks restart point of two
// - Disabling a queue aborts its conversion
// - Mode change aborts, restarts from first command
// - Stop bit aborts conversion in progress
// - Debug freeze halts after current conversion
// - 64 ten-bit result entries, read and write
// - Read address picks result alignment format
// - Result writes always taken right-aligned
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "aqs_cfg.svh"

module aqs_sequencer
  import aqs_pkg::*;
#(
  parameter int DEPTH = 64
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_r,
  input wire logic ext_trig1,
  input wire logic ext_trig2,
  input wire logic debug_req,
  output logic [5:0] mux_chan_r,
  output logic buf_sample_r,
  output logic direct_sample_r,
  output logic conv_start_r,
  output logic conv_abort_r,
  input wire logic conv_done,
  input wire logic [9:0] conv_result,
  output logic irq_complete_r,
  output logic irq_pause_r
);

  aqs_cmd_s cmd_mem [DEPTH];
  logic [9:0] res_mem [DEPTH];
  logic [15:0] ctrl1_r;
  logic [15:0] ctrl2_r;
  logic [15:0] glob_r;
  logic [1:0] done_flag_r;
  logic [1:0] pause_flag_r;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [1:0] trg_prev_r;
  logic [7:0] presc_cnt_r;
  logic qtick_r;
  logic [16:0] tmr_cnt_r;
  logic tmr_roll_r;
  logic [1:0] run_r;
  logic [1:0] paused_r;
  logic [6:0] ptr_r [2];
  logic [6:0] sub_r [2];
  aqs_state_e state_r;
  logic cur_q_r;
  logic [5:0] cur_idx_r;
  aqs_cmd_s cur_cmd_r;
  logic [4:0] cnt_r;
  logic stop_prev_r;

  aqs_mode_e mode [2];
  logic [1:0] sse;
  logic [1:0] single;
  logic [1:0] trig;
  logic [1:0] use_tmr;
  logic [1:0] mode_chg;
  logic [1:0] ev_done;
  logic [1:0] ev_pause;
  logic [1:0] abort_q;
  logic [6:0] start_ptr [2];
  logic [6:0] base_ptr;
  logic [1:0] edge_hit;
  logic gate_hi;
  logic dbg_sync;
  logic frozen;
  logic stop_on;
  logic fetch;
  logic sel_q;
  logic [6:0] fptr;
  aqs_cmd_s fcmd;
  logic end_hit;
  logic gate_close;
  logic abort_any;
  logic done_ok;
  logic wr_cmd;
  logic wr_res;
  logic [16:0] tmr_top;
  logic [3:0] tmr_exp;

  assign base_ptr = ctrl2_r[`AQS_F_BASE];
  assign start_ptr[0] = 7'h00;
  assign start_ptr[1] = base_ptr;
  assign gate_hi = sync2_r[0];
  assign dbg_sync = sync2_r[2];
  assign edge_hit = sync2_r[1:0] & ~trg_prev_r;
  assign stop_on = glob_r[`AQS_F_STOP];
  assign frozen = glob_r[`AQS_F_FREEZE] & dbg_sync;
  assign sse = {ctrl2_r[`AQS_F_SSE], ctrl1_r[`AQS_F_SSE]};
  assign wr_cmd = reg_wr && !reg_addr[8] && reg_addr[7:6] == `AQS_RGN_CMD;
  assign wr_res = reg_wr && !reg_addr[8] && reg_addr[7:6] != `AQS_RGN_CMD;

  always_comb
  begin
    mode[0] = aqs_decode_mode(ctrl1_r[`AQS_F_MODE]);
    mode[1] = aqs_decode_mode(ctrl2_r[`AQS_F_MODE]);
    // Gating exists on the first queue only
    if (mode[1] == AQS_GATE_SINGLE || mode[1] == AQS_GATE_CONT)
      mode[1] = AQS_DISABLED;
  end

  always_comb
  begin
    for (int q = 0; q < 2; q++)
    begin
      single[q] = 1'b0;
      trig[q] = 1'b0;
      unique case (mode[q])
        AQS_DISABLED: trig[q] = 1'b0;
        AQS_SW_SINGLE, AQS_SW_CONT: trig[q] = 1'b1;
        AQS_EXT_SINGLE, AQS_EXT_CONT: trig[q] = edge_hit[q];
        AQS_TMR_SINGLE, AQS_TMR_CONT: trig[q] = tmr_roll_r;
        AQS_GATE_SINGLE, AQS_GATE_CONT: trig[q] = gate_hi;
      endcase
      single[q] = mode[q] == AQS_SW_SINGLE || mode[q] == AQS_EXT_SINGLE ||
                  mode[q] == AQS_TMR_SINGLE || mode[q] == AQS_GATE_SINGLE;
      trig[q] = trig[q] & (!single[q] | sse[q]) & !stop_on;
      use_tmr[q] = mode[q] == AQS_TMR_CONT || (mode[q] == AQS_TMR_SINGLE && sse[q]);
    end
  end

  assign mode_chg[0] = reg_wr && reg_addr == `AQS_REG_CTRL1 && reg_wdata[`AQS_F_MODE] != ctrl1_r[`AQS_F_MODE];
  assign mode_chg[1] = reg_wr && reg_addr == `AQS_REG_CTRL2 && reg_wdata[`AQS_F_MODE] != ctrl2_r[`AQS_F_MODE];

  // Fetch decision: queue one always wins the converter
  assign fetch = state_r == AQS_ST_IDLE && !frozen && !stop_on && (run_r != 2'b00);
  assign sel_q = !run_r[0];
  assign fptr = ptr_r[sel_q];
  assign fcmd = cmd_mem[fptr[5:0]];
  assign end_hit = fptr[6] || (!sel_q && fptr >= base_ptr) || fcmd.chan == `AQS_END_CHAN;
  assign gate_close = !sel_q && !gate_hi && (mode[0] == AQS_GATE_SINGLE || mode[0] == AQS_GATE_CONT);

  always_comb
  begin
    abort_q = mode_chg;
    if (glob_r[`AQS_F_STOP] && !stop_prev_r)
      abort_q = 2'b11;
    if (trig[0] && !run_r[0])
      abort_q[1] = 1'b1;
  end
  assign abort_any = state_r != AQS_ST_IDLE && abort_q[cur_q_r];
  assign done_ok = state_r == AQS_ST_CONV && conv_done && !abort_any;

  always_comb
  begin
    ev_done = 2'b00;
    ev_pause = 2'b00;
    if (fetch && end_hit && !gate_close)
      ev_done[sel_q] = 1'b1;
    if (fetch && gate_close)
      ev_pause[0] = 1'b1;
    // Gated scans ignore pause bits
    if (done_ok && cur_cmd_r.pause && !(mode[cur_q_r] == AQS_GATE_SINGLE || mode[cur_q_r] == AQS_GATE_CONT))
      ev_pause[cur_q_r] = 1'b1;
  end

  // Input synchronisers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      trg_prev_r <= 2'h0;
      stop_prev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {debug_req, ext_trig2, ext_trig1};
      sync2_r <= sync1_r;
      trg_prev_r <= sync2_r[1:0];
      stop_prev_r <= glob_r[`AQS_F_STOP];
    end
  end

  // Converter clock prescaler
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      presc_cnt_r <= 8'h00;
      qtick_r <= 1'b0;
    end
    else if (presc_cnt_r >= glob_r[`AQS_F_PRESC])
    begin
      presc_cnt_r <= 8'h00;
      qtick_r <= 1'b1;
    end
    else
    begin
      presc_cnt_r <= presc_cnt_r + 8'h01;
      qtick_r <= 1'b0;
    end
  end

  // Periodic timer, held in reset while unused, stopped or frozen
  assign tmr_exp = (glob_r[`AQS_F_TMR_EXP] > `AQS_TMR_MAX_EXP) ? `AQS_TMR_MAX_EXP : glob_r[`AQS_F_TMR_EXP];
  // Five-bit sum so that exponents up to 17 do not wrap
  assign tmr_top = (17'h00001 << ({1'b0, tmr_exp} + 5'(`AQS_TMR_MIN_EXP))) - 17'h00001;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tmr_cnt_r <= 17'h00000;
      tmr_roll_r <= 1'b0;
    end
    else if (use_tmr == 2'b00 || stop_on || frozen || mode_chg != 2'b00)
    begin
      tmr_cnt_r <= 17'h00000;
      tmr_roll_r <= 1'b0;
    end
    else if (qtick_r && tmr_cnt_r >= tmr_top)
    begin
      tmr_cnt_r <= 17'h00000;
      tmr_roll_r <= 1'b1;
    end
    else
    begin
      tmr_cnt_r <= tmr_cnt_r + {16'h0000, qtick_r};
      tmr_roll_r <= 1'b0;
    end
  end

  // Control registers and sticky flags
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl1_r <= `AQS_CTRL1_RST;
      ctrl2_r <= `AQS_CTRL2_RST;
      glob_r <= `AQS_GLOBAL_RST;
      done_flag_r <= 2'b00;
      pause_flag_r <= 2'b00;
    end
    else
    begin
      if (reg_wr && reg_addr == `AQS_REG_CTRL1)
        ctrl1_r <= reg_wdata & `AQS_CTRL1_MASK;
      else if (ev_done[0] && single[0])
        ctrl1_r[`AQS_F_SSE] <= 1'b0;
      if (reg_wr && reg_addr == `AQS_REG_CTRL2)
        ctrl2_r <= reg_wdata & `AQS_CTRL2_MASK;
      else if (ev_done[1] && single[1])
        ctrl2_r[`AQS_F_SSE] <= 1'b0;
      if (reg_wr && reg_addr == `AQS_REG_GLOBAL)
        glob_r <= reg_wdata & `AQS_GLOBAL_MASK;
      // Hardware set wins over a write-one clear in the same cycle
      if (reg_wr && reg_addr == `AQS_REG_STATUS)
      begin
        done_flag_r <= (done_flag_r & ~{reg_wdata[2], reg_wdata[0]}) | ev_done;
        pause_flag_r <= (pause_flag_r & ~{reg_wdata[3], reg_wdata[1]}) | ev_pause;
      end
      else
      begin
        done_flag_r <= done_flag_r | ev_done;
        pause_flag_r <= pause_flag_r | ev_pause;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_complete_r <= 1'b0;
      irq_pause_r <= 1'b0;
    end
    else
    begin
      irq_complete_r <= |(done_flag_r & {ctrl2_r[`AQS_F_IE_DONE], ctrl1_r[`AQS_F_IE_DONE]});
      irq_pause_r <= |(pause_flag_r & {ctrl2_r[`AQS_F_IE_PAUSE], ctrl1_r[`AQS_F_IE_PAUSE]});
    end
  end

  // Queue pointers and run state
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_r <= 2'b00;
      paused_r <= 2'b00;
      ptr_r[0] <= 7'h00;
      ptr_r[1] <= 7'h00;
      sub_r[0] <= 7'h00;
      sub_r[1] <= 7'h00;
    end
    else
    begin
      for (int q = 0; q < 2; q++)
      begin
        if (mode_chg[q])
        begin
          run_r[q] <= 1'b0;
          paused_r[q] <= 1'b0;
          ptr_r[q] <= start_ptr[q];
          sub_r[q] <= start_ptr[q];
        end
        else if (ev_done[q])
        begin
          run_r[q] <= 1'b0;
          paused_r[q] <= 1'b0;
          ptr_r[q] <= start_ptr[q];
          sub_r[q] <= start_ptr[q];
        end
        else if (ev_pause[q] && fetch)
        begin
          run_r[q] <= 1'b0;
          ptr_r[q] <= start_ptr[q];
          sub_r[q] <= start_ptr[q];
        end
        else if (ev_pause[q])
        begin
          run_r[q] <= 1'b0;
          paused_r[q] <= 1'b1;
          ptr_r[q] <= ptr_r[q] + 7'h01;
          sub_r[q] <= ptr_r[q] + 7'h01;
        end
        else if (done_ok && cur_q_r == q[0])
          ptr_r[q] <= ptr_r[q] + 7'h01;
        else if (trig[q] && !run_r[q])
        begin
          run_r[q] <= 1'b1;
          paused_r[q] <= 1'b0;
          if (!paused_r[q])
          begin
            ptr_r[q] <= start_ptr[q];
            sub_r[q] <= start_ptr[q];
          end
        end
      end
      // Preempted second queue backs up to the subqueue start unless resume is set
      if (trig[0] && !run_r[0] && run_r[1] && !ctrl2_r[`AQS_F_RESUME] && !mode_chg[1])
        ptr_r[1] <= sub_r[1];
    end
  end

  // Conversion sequence
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= AQS_ST_IDLE;
      cur_q_r <= 1'b0;
      cur_idx_r <= 6'h00;
      cur_cmd_r <= '0;
      cnt_r <= 5'h00;
      mux_chan_r <= 6'h00;
      buf_sample_r <= 1'b0;
      direct_sample_r <= 1'b0;
      conv_start_r <= 1'b0;
      conv_abort_r <= 1'b0;
    end
    else
    begin
      conv_start_r <= 1'b0;
      conv_abort_r <= 1'b0;
      if (abort_any)
      begin
        state_r <= AQS_ST_IDLE;
        conv_abort_r <= 1'b1;
        buf_sample_r <= 1'b0;
        direct_sample_r <= 1'b0;
      end
      else
      begin
        unique case (state_r)
          AQS_ST_IDLE:
            if (fetch && !end_hit && !gate_close)
            begin
              state_r <= AQS_ST_INIT;
              cur_q_r <= sel_q;
              cur_idx_r <= fptr[5:0];
              cur_cmd_r <= fcmd;
              mux_chan_r <= fcmd.chan;
              buf_sample_r <= 1'b1;
              cnt_r <= `AQS_INIT_SAMPLE_CONVERTER_CLOCK;
            end
          AQS_ST_INIT:
            if (qtick_r && cnt_r == 5'h01)
            begin
              state_r <= AQS_ST_FINAL;
              buf_sample_r <= 1'b0;
              direct_sample_r <= 1'b1;
              cnt_r <= 5'h02 << cur_cmd_r.sample_sel;
            end
            else if (qtick_r)
              cnt_r <= cnt_r - 5'h01;
          AQS_ST_FINAL:
            if (qtick_r && cnt_r == 5'h01)
            begin
              state_r <= AQS_ST_CONV;
              direct_sample_r <= 1'b0;
              conv_start_r <= 1'b1;
            end
            else if (qtick_r)
              cnt_r <= cnt_r - 5'h01;
          AQS_ST_CONV:
            if (conv_done)
              state_r <= AQS_ST_IDLE;
        endcase
      end
    end
  end

  // Command table: only software writes it
  always_ff @(posedge clk)
  begin
    if (wr_cmd)
      cmd_mem[reg_addr[5:0]] <= aqs_cmd_s'(reg_wdata[9:0]);
  end

  // Result table: a finishing conversion wins over a software write
  always_ff @(posedge clk)
  begin
    if (done_ok)
      res_mem[cur_idx_r] <= conv_result;
    else if (wr_res)
      res_mem[reg_addr[5:0]] <= reg_wdata[9:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata_r <= 16'h0000;
    else if (!reg_rd)
      reg_rdata_r <= 16'h0000;
    else if (!reg_addr[8])
    begin
      unique case (reg_addr[7:6])
        `AQS_RGN_CMD: reg_rdata_r <= {6'h00, cmd_mem[reg_addr[5:0]]};
        `AQS_RGN_RIGHT: reg_rdata_r <= {6'h00, res_mem[reg_addr[5:0]]};
        `AQS_RGN_SIGNED: reg_rdata_r <= {~res_mem[reg_addr[5:0]][9], res_mem[reg_addr[5:0]][8:0], 6'h00};
        `AQS_RGN_LEFT: reg_rdata_r <= {res_mem[reg_addr[5:0]], 6'h00};
      endcase
    end
    else
    begin
      unique case (reg_addr)
        `AQS_REG_CTRL1: reg_rdata_r <= ctrl1_r;
        `AQS_REG_CTRL2: reg_rdata_r <= ctrl2_r;
        `AQS_REG_GLOBAL: reg_rdata_r <= glob_r;
        `AQS_REG_STATUS: reg_rdata_r <= {1'b0, ptr_r[cur_q_r], 2'b00, run_r,
                                         pause_flag_r[1], done_flag_r[1], pause_flag_r[0], done_flag_r[0]};
        default: reg_rdata_r <= 16'h0000;
      endcase
    end
  end

endmodule : aqs_sequencer

// ===== sim/aqs_chk.sv
// Port assertions for the queue sequencer.
// Assumes the prescaler keeps a tick of at least four clocks.
`timescale 1ns/1ps
module aqs_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata_r,
  input wire logic [5:0] mux_chan_r,
  input wire logic buf_sample_r,
  input wire logic direct_sample_r,
  input wire logic conv_start_r,
  input wire logic conv_abort_r,
  input wire logic conv_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 16'h0000)
    else $error("read data not zero");
  cmd_upper_zero_a: assert property ($past(reg_rd) && $past(reg_addr[8:6]) == 3'h0 |-> reg_rdata_r[15:10] == 6'h00)
    else $error("command upper bits set");
  right_upper_zero_a: assert property ($past(reg_rd) && $past(reg_addr[8:6]) == 3'h1 |-> reg_rdata_r[15:10] == 6'h00)
    else $error("right format upper bits set");
  left_low_zero_a: assert property ($past(reg_rd) && $past(reg_addr[8:7]) == 2'h1 |-> reg_rdata_r[5:0] == 6'h00)
    else $error("left format low bits set");
  phase_excl_a: assert property (!(buf_sample_r && direct_sample_r))
    else $error("both sample phases");
  init_first_a: assert property ($rose(direct_sample_r) |-> $past(buf_sample_r))
    else $error("final sample without initial");
  final_min_a: assert property ($rose(direct_sample_r) |-> direct_sample_r [*5] or (##[0:4] conv_abort_r))
    else $error("final sample too short");
  start_after_a: assert property (conv_start_r |-> $past(direct_sample_r) ##1 !conv_start_r)
    else $error("start not after final sample");
  abort_stops_a: assert property (conv_abort_r |=> !direct_sample_r && !conv_start_r)
    else $error("sampling kept after abort");
  end_not_conv_a: assert property (buf_sample_r |-> mux_chan_r != 6'h3f)
    else $error("end marker sampled");
  chan_hold_a: assert property ((buf_sample_r || direct_sample_r) && $past(buf_sample_r || direct_sample_r)
    |-> $stable(mux_chan_r))
    else $error("channel moved in sampling");

  cover property (conv_start_r ##[1:200] conv_done);
  cover property (conv_abort_r);
  cover property ($rose(direct_sample_r));
endmodule : aqs_chk

bind aqs_sequencer aqs_chk u_chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .mux_chan_r(mux_chan_r),
  .buf_sample_r(buf_sample_r), .direct_sample_r(direct_sample_r), .conv_start_r(conv_start_r),
  .conv_abort_r(conv_abort_r), .conv_done(conv_done));

// ===== sim/aqs_core_model.sv
// Converter core model: converts after a fixed latency, logs channels.
// Assumes start and abort are one-cycle pulses in the clk domain.
`timescale 1ns/1ps
module aqs_core_model #(
  parameter int LAT = 12
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [5:0] chan,
  output logic done,
  output logic [9:0] result
);
  logic busy_r;
  int cnt_r;
  logic [5:0] chan_r;
  logic [5:0] seen [16];
  logic [7:0] seen_cnt;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      busy_r <= 1'b0;
      done <= 1'b0;
      cnt_r <= 0;
      chan_r <= 6'h00;
      seen_cnt <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
        busy_r <= 1'b0;
      else if (start)
      begin
        busy_r <= 1'b1;
        cnt_r <= LAT;
        chan_r <= chan;
      end
      else if (busy_r && cnt_r == 0)
      begin
        busy_r <= 1'b0;
        done <= 1'b1;
        seen[seen_cnt[3:0]] <= chan_r;
        seen_cnt <= seen_cnt + 8'h01;
      end
      else if (busy_r)
        cnt_r <= cnt_r - 1;
    end

  // Stale value is inverted so it never passes for a result
  assign result = done ? {4'h9, chan_r} : ~{4'h9, chan_r};
endmodule : aqs_core_model

// ===== sim/adc_queue_sequencer_tb_top.sv
// Self-checking bench for the queue sequencer.
// Assumes the converter core model and the bound checker.
`timescale 1ns/1ps
module adc_queue_sequencer_tb_top;
  typedef struct {logic [8:0] wa; logic [15:0] wd; logic [8:0] ra; logic [15:0] ex;} aqs_row_s;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_trig1 = 1'b0;
  logic ext_trig2 = 1'b0;
  logic debug_req = 1'b0;
  logic [15:0] reg_rdata_r;
  logic [5:0] mux_chan_r;
  logic buf_sample_r, direct_sample_r, conv_start_r, conv_abort_r, conv_done, irq_complete_r, irq_pause_r;
  logic [9:0] conv_result;
  int mismatches = 0;
  int samples_checked = 0;
  aqs_row_s rows [7] = '{'{9'h000, 16'hffff, 9'h000, 16'h03ff}, '{9'h03f, 16'h0155, 9'h03f, 16'h0155},
    '{9'h040, 16'hfe55, 9'h040, 16'h0255}, '{9'h081, 16'h0201, 9'h041, 16'h0201},
    '{9'h0c1, 16'h0201, 9'h081, 16'h0040}, '{9'h0c1, 16'h0201, 9'h0c1, 16'h8040},
    '{9'h1ff, 16'h1234, 9'h1ff, 16'h0000}};

  always #4 clk = ~clk;

  aqs_sequencer DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .ext_trig1(ext_trig1), .ext_trig2(ext_trig2),
    .debug_req(debug_req), .mux_chan_r(mux_chan_r), .buf_sample_r(buf_sample_r),
    .direct_sample_r(direct_sample_r), .conv_start_r(conv_start_r), .conv_abort_r(conv_abort_r),
    .conv_done(conv_done), .conv_result(conv_result), .irq_complete_r(irq_complete_r), .irq_pause_r(irq_pause_r));

  aqs_core_model #(.LAT(12)) u_core (.clk(clk), .sys_rst(sys_rst), .start(conv_start_r), .abort(conv_abort_r),
    .chan(mux_chan_r), .done(conv_done), .result(conv_result));

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata_r;
  endtask : rd

  task automatic wt(input int sel);
    for (int i = 0; i < 3000; i++)
    begin
      @(negedge clk);
      if ((sel == 0 && irq_complete_r === 1'b1) || (sel == 1 && irq_pause_r === 1'b1) ||
          (sel == 2 && buf_sample_r === 1'b1) || (sel == 3 && conv_abort_r === 1'b1))
        return;
    end
    chk("wait", 16'h0001, 16'h0000);
  endtask : wt

  task automatic cv(input int n0, input int n, input logic [5:0] ch);
    chk("conv_count", 16'(n), 16'(int'(u_core.seen_cnt) - n0));
    chk("conv_chan", {10'h000, ch}, {10'h000, u_core.seen[u_core.seen_cnt[3:0] - 4'h1]});
  endtask : cv

  task automatic trig();
    @(posedge clk);
    ext_trig1 <= 1'b1;
    repeat (4) @(posedge clk);
    ext_trig1 <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : trig

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  initial
  begin
    repeat (60000) @(posedge clk);
    chk("watchdog", 16'h0001, 16'h0000);
    close_out();
  end

  initial
  begin
    logic [15:0] d;
    int n0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(9'h101, d);
    chk("ctrl2_reset", 16'h4000, d);
    rd(9'h102, d);
    chk("global_reset", 16'h0300, d);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, d);
      chk("table", rows[i].ex, d);
    end
    $display("test tables done");
    wr(9'h000, 16'h0005);
    wr(9'h001, 16'h0049);
    wr(9'h002, 16'h0007);
    wr(9'h003, 16'h003f);
    wr(9'h101, 16'h0200);
    n0 = u_core.seen_cnt;
    wr(9'h100, 16'h0051);
    wt(0);
    cv(n0, 2, 6'd9);
    rd(9'h040, d);
    chk("result0", 16'h0245, d);
    rd(9'h041, d);
    chk("result1", 16'h0249, d);
    rd(9'h103, d);
    chk("done1", 16'h0001, {15'h0000, d[0]});
    wr(9'h103, 16'h000f);
    repeat (3) @(negedge clk);
    chk("irq_clear", 16'h0000, {15'h0000, irq_complete_r});
    $display("test queue one done");
    wr(9'h100, 16'h0000);
    n0 = u_core.seen_cnt;
    wr(9'h101, 16'h0251);
    wt(0);
    cv(n0, 1, 6'd7);
    wr(9'h103, 16'h000f);
    wr(9'h101, 16'h4000);
    $display("test queue two done");
    wr(9'h000, 16'h0105);
    wr(9'h002, 16'h003f);
    n0 = u_core.seen_cnt;
    wr(9'h100, 16'h00c4);
    trig();
    wt(1);
    cv(n0, 1, 6'd5);
    wr(9'h103, 16'h0002);
    trig();
    wt(0);
    cv(n0, 2, 6'd9);
    wr(9'h103, 16'h000f);
    wr(9'h100, 16'h0000);
    $display("test pause done");
    wr(9'h100, 16'h0011);
    wt(2);
    wr(9'h100, 16'h0000);
    wt(3);
    wr(9'h100, 16'h0011);
    wt(2);
    wr(9'h100, 16'h0012);
    wt(3);
    wt(2);
    wr(9'h102, 16'h0301);
    wt(3);
    wr(9'h102, 16'h0300);
    wr(9'h100, 16'h0000);
    $display("test abort done");
    wr(9'h103, 16'h000f);
    wr(9'h000, 16'h0005);
    wr(9'h001, 16'h003f);
    wr(9'h002, 16'h0007);
    n0 = u_core.seen_cnt;
    wr(9'h101, 16'h0251);
    wt(2);
    wr(9'h100, 16'h0011);
    wt(3);
    wt(0);
    cv(n0, 2, 6'd7);
    wr(9'h103, 16'h000f);
    wr(9'h101, 16'h4000);
    $display("test preempt done");
    wr(9'h102, 16'h0302);
    debug_req <= 1'b1;
    n0 = u_core.seen_cnt;
    wr(9'h100, 16'h0051);
    repeat (80) @(negedge clk);
    chk("frozen", 16'(n0), 16'(int'(u_core.seen_cnt)));
    @(posedge clk);
    debug_req <= 1'b0;
    wt(0);
    cv(n0, 1, 6'd5);
    wr(9'h102, 16'h0300);
    wr(9'h100, 16'h0000);
    $display("test freeze done");
    close_out();
  end
endmodule : adc_queue_sequencer_tb_top
